/* rtl/nsa_pkg.sv */
package nsa_pkg;
    localparam int unsigned CLK_MHZ     = 20;
    // register byte offsets
    localparam logic [7:0] OFF_ADDR_LO  = 8'h00;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h04;
    localparam logic [7:0] OFF_DATA_LO  = 8'h08;
    localparam logic [7:0] OFF_DATA_HI  = 8'h0C;
    localparam logic [7:0] OFF_CTRL     = 8'h10;
    localparam logic [7:0] OFF_KEY      = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    // control register fields
    localparam int unsigned BIT_RD      = 0;
    localparam int unsigned BIT_WR      = 1;
    localparam int unsigned BIT_WRITE_ENABLE_BIT    = 2;
    localparam int unsigned BIT_WRITE_ERROR_FLAG   = 3;
    localparam int unsigned BIT_FREE    = 4;
    localparam int unsigned BIT_LWLO    = 5;
    localparam int unsigned BIT_CONFIG_SPACE_SELECT    = 6;
    localparam int unsigned BIT_PGM     = 7;
    // status register fields
    localparam int unsigned BIT_DONE    = 0;
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'hAA;
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [13:0] LATCH_RST   = 14'h3FFF;
    localparam logic [14:0] PROT_LIM_LO = 15'h0200;
    localparam logic [14:0] PROT_LIM_HI = 15'h0400;
    // timing
    localparam int unsigned ERASE_US    = 2000;
    localparam int unsigned PROG_US     = 2000;
    localparam int unsigned EE_WR_US    = 4000;
    localparam int unsigned PWRT_MS     = 64;
    localparam int unsigned SETUP_CYC   = 2;
    localparam int unsigned ERASE_CYC   = ERASE_US * CLK_MHZ;
    localparam int unsigned PROG_CYC    = PROG_US * CLK_MHZ;
    localparam int unsigned EE_WR_CYC   = EE_WR_US * CLK_MHZ;
    localparam int unsigned PWRT_CYC    = PWRT_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {OP_READ, OP_EEWR, OP_ERASE, OP_PROG} nsa_op_t;
    typedef enum logic [2:0] {
        US_IDLE  = 3'b001,
        US_KEY1  = 3'b010,
        US_ARMED = 3'b100
    } nsa_ustate_t;
    typedef enum logic [3:0] {
        SQ_IDLE  = 4'b0001,
        SQ_SETUP = 4'b0010,
        SQ_BUSY  = 4'b0100,
        SQ_DONE  = 4'b1000
    } nsa_sstate_t;

    // segment guarded by the self-write protect field
    function automatic logic wr_protected(input logic [14:0] addr, input logic [1:0] fld);
        case (fld)
            2'h3:    wr_protected = 1'b0;
            2'h2:    wr_protected = addr < PROT_LIM_LO;
            2'h1:    wr_protected = addr < PROT_LIM_HI;
            default: wr_protected = 1'b1;
        endcase
    endfunction
endpackage

/* rtl/nsa_op_if.sv */
`timescale 1ns/100ps
interface nsa_op_if;
    import nsa_pkg::*;
    logic    start;
    nsa_op_t op;
    logic    busy;
    logic    done;
    logic    skip;
    logic    stall;
    logic    rd_stb;
    logic    arr_stb;
    modport ctrl (output start, op, input busy, done, skip, stall, rd_stb, arr_stb);
    modport seq  (input start, op, output busy, done, skip, stall, rd_stb, arr_stb);
endinterface

/* rtl/nsa_unlock.sv */
`timescale 1ns/100ps
module nsa_unlock (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       key_wr_i,
    input  wire logic [7:0] key_i,
    input  wire logic       other_wr_i,
    output logic            armed_o
);
    import nsa_pkg::*;
    nsa_ustate_t st_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= US_IDLE;
        end else if (other_wr_i) begin
            st_q <= US_IDLE;
        end else if (key_wr_i) begin
            case (st_q)
                US_IDLE: st_q  <= (key_i == KEY_FIRST) ? US_KEY1 : US_IDLE;
                US_KEY1: st_q  <= (key_i == KEY_SECOND) ? US_ARMED : US_IDLE;
                default: st_q  <= US_IDLE;
            endcase
        end
    end

    assign armed_o = (st_q == US_ARMED);
endmodule

/* rtl/nsa_seq.sv */
`timescale 1ns/100ps
module nsa_seq #(
    parameter int unsigned ERASE_N = 40000,
    parameter int unsigned PROG_N  = 40000,
    parameter int unsigned EE_N    = 80000
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    nsa_op_if.seq     op_if
);
    import nsa_pkg::*;
    nsa_sstate_t st_q;
    logic [31:0] cnt_q;
    logic [31:0] len;
    logic        pf;

    always_comb begin
        case (op_if.op)
            OP_READ:  len = 32'd1;
            OP_EEWR:  len = EE_N;
            OP_ERASE: len = ERASE_N;
            default:  len = PROG_N;
        endcase
    end
    assign pf = (op_if.op == OP_ERASE) || (op_if.op == OP_PROG);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q  <= SQ_IDLE;
            cnt_q <= '0;
        end else begin
            case (st_q)
                SQ_IDLE: begin
                    cnt_q <= '0;
                    if (op_if.start) st_q <= SQ_SETUP;
                end
                // two set-up cycles before the halt
                SQ_SETUP: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (op_if.op == OP_READ || cnt_q == 32'(SETUP_CYC - 1)) begin
                        st_q  <= SQ_BUSY;
                        cnt_q <= '0;
                    end
                end
                SQ_BUSY: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q == len - 32'd1) st_q <= SQ_DONE;
                end
                default: st_q <= SQ_IDLE;
            endcase
        end
    end

    assign op_if.busy    = (st_q != SQ_IDLE);
    assign op_if.done    = (st_q == SQ_DONE);
    assign op_if.skip    = ((st_q == SQ_SETUP) && pf) || ((st_q == SQ_BUSY) && !pf
                           && op_if.op == OP_READ);
    assign op_if.stall   = (st_q == SQ_BUSY) && pf;
    assign op_if.rd_stb  = (st_q == SQ_BUSY) && (op_if.op == OP_READ);
    assign op_if.arr_stb = (st_q == SQ_BUSY) && (cnt_q == '0) && (op_if.op != OP_READ);
endmodule

/* rtl/nsa_ctrl.sv */
`timescale 1ns/100ps
// Operation
// - write starts only after 55h, AAh, start
// - start refused without write enable set
// - hardware never clears write enable
// - dropping write enable never aborts write
// - finish clears start, sets done flag
// - power-up clears enable; timer blocks writes
// - protect fuse low locks programmer out
// - no flash write into protected segment
// - erase whole aligned 16-word rows only
// - flash data goes through 14-bit latches
// - second cycle reads array, word follows
// - data registers hold until read or write
// - cpu reads flash regardless of protection
// - two set-up cycles then cpu halt
// - resume at third instruction after start
// - space select clear means data eeprom
// - start bits set-only, cleared by hardware
// - reset during write sets error flag
// - key register reads as zero
module nsa_ctrl #(
    parameter int unsigned ERASE_N = nsa_pkg::ERASE_CYC,
    parameter int unsigned PROG_N  = nsa_pkg::PROG_CYC,
    parameter int unsigned EE_N    = nsa_pkg::EE_WR_CYC,
    parameter int unsigned PWRT_N  = nsa_pkg::PWRT_CYC,
    parameter int unsigned LATCHES = 16
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        data_protect_fuse_i,
    input  wire logic [1:0]  self_write_protect_field_i,
    output logic             prog_ee_allow_o,
    output logic [14:0]      mem_addr_o,
    output logic             mem_space_o,
    output logic             mem_rd_o,
    input  wire logic [13:0] mem_rdata_i,
    output logic [7:0]       mem_wdata_o,
    output logic             mem_ee_wr_o,
    output logic             mem_erase_o,
    output logic             mem_prog_o,
    input  wire logic [3:0]  mem_latch_sel_i,
    output logic [13:0]      mem_latch_o,
    output logic             cpu_stall_o,
    output logic             cpu_skip_o
);
    import nsa_pkg::*;

    if (LATCHES != 16 || ERASE_N < 1 || PROG_N < 1 || EE_N < 1 || PWRT_N < 1) begin : g_chk
        $error("nsa_ctrl: unsupported parameter values");
    end

    nsa_op_if op_if ();

    logic        dp_wr_q;
    logic        dp_rd_q;
    logic [7:0]  dp_addr_q;
    logic [7:0]  addr_lo_q;
    logic [6:0]  addr_hi_q;
    logic [7:0]  data_lo_q;
    logic [5:0]  data_hi_q;
    logic        rd_q;
    logic        wr_q;
    logic        write_enable_bit_q;
    logic        write_error_flag_q;
    logic        free_q;
    logic        lwlo_q;
    logic        config_space_select_q;
    logic        pgm_q;
    logic        done_flag_q;
    logic [31:0] pwrt_cnt_q;
    logic        pwrt_busy;
    logic        armed;
    logic        prot_hit;
    logic        ctrl_wr;
    logic        wr_go;
    logic        rd_go;
    logic        latch_ld;
    logic [14:0] full_addr;
    logic [13:0] latch_q [LATCHES];
    logic [7:0]  ctrl_rd;
    nsa_op_t     op_sel;
    nsa_op_t     op_q;

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = dp_wr_q && (dp_addr_q == off);
    endfunction

    // address phase captured; only whole-word writes reach the registers, reads of any size are answered
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || sys_rst_i) begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= '0;
        end else if (hready_i) begin
            dp_wr_q   <= hsel_i && htrans_i[1] && hwrite_i && (hsize_i == 3'h2);
            dp_rd_q   <= hsel_i && htrans_i[1] && !hwrite_i;
            dp_addr_q <= haddr_i[7:0];
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    assign ctrl_rd = {pgm_q, config_space_select_q, lwlo_q, free_q, write_error_flag_q, write_enable_bit_q, wr_q, rd_q};

    always_comb begin
        hrdata_o = '0;
        if (dp_rd_q) begin
            case (dp_addr_q)
                OFF_ADDR_LO: hrdata_o = {24'h0000_00, addr_lo_q};
                OFF_ADDR_HI: hrdata_o = {25'h0, addr_hi_q};
                OFF_DATA_LO: hrdata_o = {24'h0000_00, data_lo_q};
                OFF_DATA_HI: hrdata_o = {26'h0, data_hi_q};
                OFF_CTRL:    hrdata_o = {24'h0000_00, ctrl_rd};
                OFF_STATUS:  hrdata_o = {31'h0, done_flag_q};
                default:     hrdata_o = '0;
            endcase
        end
    end

    nsa_unlock u_unlock (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i || sys_rst_i),
        .key_wr_i   (wr_to(OFF_KEY)),
        .key_i      (hwdata_i[7:0]),
        .other_wr_i (dp_wr_q && (dp_addr_q != OFF_KEY)),
        .armed_o    (armed)
    );

    nsa_seq #(
        .ERASE_N (ERASE_N),
        .PROG_N  (PROG_N),
        .EE_N    (EE_N)
    ) u_seq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i || sys_rst_i),
        .op_if     (op_if)
    );

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pwrt_cnt_q <= '0;
        end else if (pwrt_busy) begin
            pwrt_cnt_q <= pwrt_cnt_q + 32'd1;
        end
    end
    assign pwrt_busy = (pwrt_cnt_q < 32'(PWRT_N));

    assign full_addr = {addr_hi_q, addr_lo_q};
    assign prot_hit  = wr_protected(full_addr, self_write_protect_field_i);
    assign ctrl_wr   = wr_to(OFF_CTRL);

    // write enable must already be set
    assign wr_go = ctrl_wr && hwdata_i[BIT_WR] && armed && write_enable_bit_q && !pwrt_busy
                   && !op_if.busy && !wr_q && !(pgm_q && prot_hit);
    // latch-load request does not start the array
    assign latch_ld = wr_go && pgm_q && !free_q && lwlo_q;
    assign rd_go    = ctrl_wr && hwdata_i[BIT_RD] && !op_if.busy && !rd_q && !wr_q;

    assign op_if.start = (wr_go && !latch_ld) || rd_go;
    assign op_sel   = rd_go ? OP_READ : !pgm_q ? OP_EEWR : free_q ? OP_ERASE : OP_PROG;
    assign op_if.op = op_if.start ? op_sel : op_q;
    // the run's kind is held: rd_go drops after the start cycle; the mode bits are frozen while it is busy
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || sys_rst_i) begin
            op_q <= OP_READ;
        end else if (op_if.start) begin
            op_q <= op_sel;
        end
    end

    // software-owned address registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_lo_q <= REG_RST;
            addr_hi_q <= '0;
        end else begin
            if (wr_to(OFF_ADDR_LO)) addr_lo_q <= hwdata_i[7:0];
            if (wr_to(OFF_ADDR_HI)) addr_hi_q <= hwdata_i[6:0];
        end
    end

    // space select resets to data eeprom
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || sys_rst_i) begin
            free_q <= 1'b0;
            lwlo_q <= 1'b0;
            config_space_select_q <= 1'b0;
            pgm_q  <= 1'b0;
        end else if (ctrl_wr && !op_if.busy) begin
            free_q <= hwdata_i[BIT_FREE];
            lwlo_q <= hwdata_i[BIT_LWLO];
            config_space_select_q <= hwdata_i[BIT_CONFIG_SPACE_SELECT];
            pgm_q  <= hwdata_i[BIT_PGM];
        end
    end

    // only power-up or software changes it
    // busy write ignores later changes here
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_enable_bit_q <= 1'b0;
        end else if (ctrl_wr) begin
            write_enable_bit_q <= hwdata_i[BIT_WRITE_ENABLE_BIT];
        end
    end

    // set by software, cleared by hardware
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || sys_rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            if (rd_go) begin
                rd_q <= 1'b1;
            end else if (op_if.done && op_if.op == OP_READ) begin
                rd_q <= 1'b0;
            end
            if (wr_go && !latch_ld) begin
                wr_q <= 1'b1;
            end else if (op_if.done && op_if.op != OP_READ) begin
                wr_q <= 1'b0;
            end
        end
    end

    // warm reset during a write leaves a mark
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            write_error_flag_q <= 1'b0;
        end else if (sys_rst_i) begin
            write_error_flag_q <= write_error_flag_q || wr_q;
        end else if (ctrl_wr) begin
            write_error_flag_q <= hwdata_i[BIT_WRITE_ERROR_FLAG];
        end
    end

    // done flag set, set wins over clear
    // cleared only by a software write of one
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            done_flag_q <= 1'b0;
        end else if (op_if.done && op_if.op != OP_READ) begin
            done_flag_q <= 1'b1;
        end else if (wr_to(OFF_STATUS) && hwdata_i[BIT_DONE]) begin
            done_flag_q <= 1'b0;
        end
    end

    // read result held until next read or write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_lo_q <= REG_RST;
            data_hi_q <= '0;
        end else if (op_if.done && op_if.op == OP_READ) begin
            data_lo_q <= mem_rdata_i[7:0];
            if (pgm_q) data_hi_q <= mem_rdata_i[13:8];
        end else begin
            if (wr_to(OFF_DATA_LO)) data_lo_q <= hwdata_i[7:0];
            if (wr_to(OFF_DATA_HI)) data_hi_q <= hwdata_i[5:0];
        end
    end

    // hidden write latches, reset to LATCH_RST after programming
    for (genvar i = 0; i < LATCHES; i++) begin : g_latch
        always_ff @(posedge clk_sys_i) begin
            if (rst_i || (op_if.done && op_if.op == OP_PROG)) begin
                latch_q[i] <= LATCH_RST;
            end else if ((latch_ld || (op_if.start && op_if.op == OP_PROG))
                         && addr_lo_q[3:0] == 4'(i)) begin
                latch_q[i] <= {data_hi_q, data_lo_q};
            end
        end
    end

    // array port; address frozen at start so software edits cannot disturb it
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mem_addr_o  <= '0;
            mem_space_o <= 1'b0;
            mem_wdata_o <= '0;
            mem_latch_o <= LATCH_RST;
        end else begin
            if (op_if.start) begin
                mem_addr_o  <= (op_if.op == OP_ERASE || op_if.op == OP_PROG) ?
                               {full_addr[14:4], 4'h0} : full_addr;
                mem_space_o <= pgm_q;
                mem_wdata_o <= data_lo_q;
            end
            mem_latch_o <= latch_q[mem_latch_sel_i];
        end
    end

    // reads never gated by code protection
    assign mem_rd_o    = op_if.rd_stb;
    assign mem_ee_wr_o = op_if.arr_stb && (op_if.op == OP_EEWR);
    assign mem_erase_o = op_if.arr_stb && (op_if.op == OP_ERASE);
    assign mem_prog_o  = op_if.arr_stb && (op_if.op == OP_PROG);
    assign cpu_stall_o = op_if.stall;
    assign cpu_skip_o  = op_if.skip;

    // programmer port locked when fuse low
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prog_ee_allow_o <= 1'b0;
        end else begin
            prog_ee_allow_o <= data_protect_fuse_i;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i || sys_rst_i);

    sequence skip_two;
        cpu_skip_o [*2];
    endsequence
    sequence read_pipe;
        !cpu_skip_o ##1 (cpu_skip_o && mem_rd_o) ##2 !rd_q;
    endsequence

    key_reads_zero_a: assert property (
        (dp_rd_q && dp_addr_q == OFF_KEY) |-> hrdata_o == 32'h0000_0000)
        else $error("key register read not zero");
    write_enable_bit_hold_a: assert property (
        !ctrl_wr |=> $stable(write_enable_bit_q))
        else $error("write enable changed without a write");
    start_needs_write_enable_bit_a: assert property (
        $rose(wr_q) |-> $past(write_enable_bit_q))
        else $error("write started without write enable");
    start_needs_key_a: assert property (
        $rose(wr_q) |-> $past(armed) && $past(ctrl_wr))
        else $error("write started without unlock");
    pwrt_blocks_a: assert property (
        $rose(wr_q) |-> !$past(pwrt_busy))
        else $error("write started under power-up timer");
    prot_blocks_a: assert property (
        $rose(wr_q) && pgm_q |-> !$past(prot_hit))
        else $error("flash write into protected segment");
    erase_stall_a: assert property (
        $rose(wr_q) && pgm_q && free_q |-> skip_two ##1 cpu_stall_o)
        else $error("erase set-up or halt misplaced");
    read_timing_a: assert property (
        $rose(rd_q) |-> read_pipe)
        else $error("read access timing wrong");
    done_sets_a: assert property (
        $fell(wr_q) && !$past(sys_rst_i) |-> done_flag_q)
        else $error("done flag not set at finish");
    done_sticky_a: assert property (
        done_flag_q && !wr_to(OFF_STATUS) |=> done_flag_q)
        else $error("done flag cleared by hardware");
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
    import nsa_pkg::*;
    localparam logic [31:0] RD = 32'h1 << BIT_RD, WR = 32'h1 << BIT_WR;
    localparam logic [31:0] WE = 32'h1 << BIT_WRITE_ENABLE_BIT, ER = 32'h1 << BIT_FREE;
    localparam logic [31:0] PG = 32'h1 << BIT_PGM, LW = 32'h1 << BIT_LWLO;
    logic        clk_sys_i, rst_i, sys_rst_i, hsel, hwrite, hreadyout, fuse;
    logic [31:0] haddr, hwdata, hrdata, rd_q, r;
    logic [1:0]  htrans, fld;
    logic [2:0]  hsize;
    logic        rdy_q, allow, space, ee_wr, erase, stall, skip, hresp, mrd;
    logic [14:0] maddr;
    logic [13:0] latch;
    logic [7:0]  wdata;
    logic [3:0]  lsel;
    int          err_total, samples_checked, n_ee, n_er, n_stall, n_skip, n_rd;

    nsa_ctrl #(.ERASE_N(5), .PROG_N(5), .EE_N(5), .PWRT_N(8)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .hrdata_o(hrdata), .data_protect_fuse_i(fuse), .self_write_protect_field_i(fld),
        .prog_ee_allow_o(allow), .mem_addr_o(maddr), .mem_space_o(space), .mem_rd_o(mrd),
        .mem_rdata_i(14'h2A5C), .mem_wdata_o(wdata), .mem_ee_wr_o(ee_wr),
        .mem_erase_o(erase), .mem_prog_o(), .mem_latch_sel_i(lsel), .mem_latch_o(latch),
        .cpu_stall_o(stall), .cpu_skip_o(skip));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // answers are captured at the edge so the data phase value is not lost to a race
    always @(posedge clk_sys_i) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
        n_ee <= n_ee + int'(ee_wr === 1'b1);
        n_er <= n_er + int'(erase === 1'b1);
        n_stall <= n_stall + int'(stall === 1'b1);
        n_skip <= n_skip + int'(skip === 1'b1);
        n_rd <= n_rd + int'(mrd === 1'b1);
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (rdy_q !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'b010;
        wt();
        htrans <= 2'b00; hwdata <= d;
        wt();
        r = rd_q;
    endtask
    // key steps issued back to back
    task automatic unlock(input logic [31:0] c);
        bus(1, OFF_KEY, 32'h55); bus(1, OFF_KEY, 32'hAA); bus(1, OFF_CTRL, c);
    endtask
    // polls the start bit until it drops, bounded
    task automatic poll();
        int n;
        n = 0;
        do begin bus(0, OFF_CTRL, 0); n++; end while (r[BIT_WR] !== 1'b0 && n < 40);
        `CHK(r[BIT_WR], 1'b0)
    endtask

    task automatic t_reset();
        bus(0, OFF_CTRL, 0); `CHK(r, 32'h0)
        `CHK(space, 1'b0)
        `CHK(hresp, 1'b0)
        bus(1, OFF_KEY, 32'h55); bus(0, OFF_KEY, 0); `CHK(r, 32'h0)
        repeat (10) @(posedge clk_sys_i);
    endtask
    task automatic t_refuse();
        bus(1, OFF_ADDR_LO, 32'h3C); bus(1, OFF_DATA_LO, 32'hA5);
        unlock(WR); bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b0)
        bus(1, OFF_CTRL, WE); bus(1, OFF_KEY, 32'h55); bus(1, OFF_ADDR_LO, 32'h3C);
        bus(1, OFF_KEY, 32'hAA); bus(1, OFF_CTRL, WE | WR);
        bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b0)
        `CHK(n_ee, 0)
    endtask
    task automatic t_eewrite();
        unlock(WE | WR); bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b1)
        poll();
        `CHK(n_ee, 1)
        `CHK(wdata, 8'hA5)
        `CHK(r[BIT_WRITE_ENABLE_BIT], 1'b1)
        bus(1, OFF_CTRL, WE | WR); bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b0)
        repeat (6) @(posedge clk_sys_i);
        bus(0, OFF_STATUS, 0); `CHK(r[BIT_DONE], 1'b1)
        bus(1, OFF_STATUS, 32'h1); bus(0, OFF_STATUS, 0); `CHK(r[BIT_DONE], 1'b0)
    endtask
    task automatic t_read();
        bus(1, OFF_ADDR_LO, 32'h45); bus(1, OFF_ADDR_HI, 32'h02);
        n_skip = 0; n_rd = 0;
        // poll reads the control register while the access runs
        bus(1, OFF_CTRL, PG | RD); poll();
        `CHK(n_skip, 1)
        `CHK(n_rd, 1)
        bus(0, OFF_DATA_LO, 0); `CHK(r[7:0], 8'h5C)
        bus(0, OFF_DATA_HI, 0); `CHK(r[5:0], 6'h2A)
        lsel <= 4'h5; repeat (2) @(posedge clk_sys_i); #1;
        `CHK(latch, 14'h3FFF)
        bus(1, OFF_CTRL, PG | WE | LW); unlock(PG | WE | LW | WR);
        repeat (2) @(posedge clk_sys_i); #1;
        `CHK(latch, 14'h2A5C)
        bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b0)
    endtask
    task automatic t_erase();
        fld <= 2'h0;
        bus(1, OFF_ADDR_LO, 32'h23); bus(1, OFF_ADDR_HI, 32'h01);
        bus(1, OFF_CTRL, PG | ER | WE);
        unlock(PG | ER | WE | WR); bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b0)
        fld <= 2'h3;
        n_stall = 0; n_skip = 0;
        unlock(PG | ER | WE | WR);
        bus(1, OFF_CTRL, PG | ER); bus(0, OFF_CTRL, 0); `CHK(r[BIT_WR], 1'b1)
        poll();
        `CHK(n_er, 1)
        `CHK(n_stall, 5)
        `CHK(n_skip, 2)
        `CHK(maddr, 15'h0120)
        bus(0, OFF_DATA_LO, 0); `CHK(r[7:0], 8'h5C)
    endtask
    task automatic t_warm();
        bus(1, OFF_CTRL, WE); unlock(WE | WR);
        @(posedge clk_sys_i); sys_rst_i <= 1'b1;
        @(posedge clk_sys_i); sys_rst_i <= 1'b0;
        bus(0, OFF_CTRL, 0); `CHK(r[BIT_WRITE_ERROR_FLAG], 1'b1)
        fuse <= 1'b0; repeat (3) @(posedge clk_sys_i); #1; `CHK(allow, 1'b0)
        fuse <= 1'b1; repeat (3) @(posedge clk_sys_i); #1; `CHK(allow, 1'b1)
    endtask

    initial begin
        err_total = 0; samples_checked = 0; n_ee = 0; n_er = 0; n_stall = 0; n_skip = 0;
        n_rd = 0; lsel = 4'h0;
        rst_i = 1'b1; sys_rst_i = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
        hwdata = 32'h0; htrans = 2'b00; hsize = 3'b010; fuse = 1'b1; fld = 2'h3;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset(); t_refuse(); t_eewrite(); t_read(); t_erase(); t_warm();
        end_sim();
    end
endmodule
